// [design/atahp_pkg.sv]
// Shared constants, carrier structs and mode helpers of the disk port.
// Assumes a single 100 MHz core clock and host pins already synchronous.
package atahp_pkg;

	// Core clock period and the timing figures that the port must honour.
	localparam int CLK_PERIOD_NS     = 10;
	localparam int IORDY_SETUP_NS    = 35;
	localparam int IORDY_MAX_LOW_NS  = 1250;
	localparam int HOST_MLI_NS       = 20;
	localparam int TRISTATE_SLOW_NS  = 30;
	localparam int TRISTATE_FAST_NS  = 20;

	// Least times round up, longest times round down; only the IORDY low limit is kept from going below one.
	localparam int IORDY_SETUP_CYC   =
		(IORDY_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IORDY_MAX_LOW_CYC =
		(IORDY_MAX_LOW_NS / CLK_PERIOD_NS < 1) ? 1 :
		IORDY_MAX_LOW_NS / CLK_PERIOD_NS;
	localparam int HOST_MLI_CYC      =
		(HOST_MLI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRISTATE_SLOW_CYC = TRISTATE_SLOW_NS / CLK_PERIOD_NS;
	localparam int TRISTATE_FAST_CYC = TRISTATE_FAST_NS / CLK_PERIOD_NS;

	// Address of the 16-bit data register and mode boundaries.
	localparam logic [2:0] DATA_REG_ADDR      = 3'h0;
	localparam logic [2:0] PIO_IOCS16_LAST    = 3'h2;
	localparam logic [2:0] PIO_NO_IORDY_FIRST = 3'h5;
	localparam logic [15:0] RDATA_RESET       = 16'h0000;

	// Pins driven by the host controller.
	typedef struct packed {
		logic        cs0_n;
		logic        cs1_n;
		logic [2:0]  addr;
		logic        rd_n;
		logic        wr_n;
		logic        dmack_n;
		logic [15:0] wdata;
	} atahp_host_in_t;

	// Pins driven by this port; an _oe_n low means the pin is driven.
	typedef struct packed {
		logic [15:0] rdata;
		logic        data_oe_n;
		logic        iordy;
		logic        iordy_oe_n;
		logic        iocs16_n;
		logic        dmarq;
	} atahp_dev_out_t;

	// Register request towards the back end.
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        width16;
		logic        cs1;
		logic [2:0]  addr;
		logic [15:0] wdata;
	} atahp_usr_req_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_HOLD = 2'b10,
		ST_DMA  = 2'b11
	} atahp_state_t;

	// Wait extension exists only below the fast PIO modes.
	function automatic logic atahp_has_iordy(input logic [2:0] m);
		return m < PIO_NO_IORDY_FIRST;
	endfunction

	// The 16-bit indication is valid only in PIO modes 0 to 2.
	function automatic logic atahp_has_iocs16(input logic [2:0] m);
		return m <= PIO_IOCS16_LAST;
	endfunction

endpackage

// [design/atahp_tmr.sv]
// One-shot cycle counter used for the wait limit and the DMA interlock.
// Assumes start is a one-cycle pulse in the core clock domain.
`timescale 1ns/1ps
module atahp_tmr
	import atahp_pkg::*;
#(
	parameter int LIMIT = 2
) (
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic start,
	output logic      done
);
	localparam int W = $clog2(LIMIT + 1);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         done;
	} atahp_tmr_t;

	atahp_tmr_t s;
	atahp_tmr_t next_s;

	// Count up from a start pulse and flag when the limit is reached.
	always_comb begin
		next_s = s;
		if (start) begin
			next_s.cnt  = '0;
			next_s.done = (LIMIT == 0);
		end else if (!s.done) begin
			next_s.cnt  = s.cnt + W'(1);
			next_s.done = (next_s.cnt == W'(LIMIT));
		end
	end

	// Idle timer reads as expired after reset.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '{cnt: '0, done: 1'b1};
		end else begin
			s <= next_s;
		end
	end

	assign done = s.done;

endmodule

// [design/atahp_port.sv]
// Device end of the parallel disk port: PIO cycles and multiword DMA.
// Assumes host pins are synchronous to core_clk and the back end answers
// register reads by raising usr_ready with usr_rdata valid.
`timescale 1ns/1ps
// Notes on behaviour
// - Transfers use all sixteen data bits or only the low eight.
// - Sixteen-bit indication driven only in PIO modes 0 to 2.
// - A wait happens only when IORDY is still low at sampling.
// - Read data is valid no later than IORDY reassertion after a wait; at the wait limit IORDY rises even with usr_ready low.
// - IORDY never stays low beyond 1250 ns within one PIO cycle.
// - PIO modes 5 and 6 have no wait; device never extends cycles.
// - Device works for any split of active and recovery time.
// - Device releases data within 30 ns, or 20 ns in fast modes.
// - Device may drop DMARQ to pause DMA and raise it to resume.
// - DMARQ falls within the bounded delay after a strobe; here it falls only when usr_dma_req drops or DMACK is released.
// - Interlocks wait for the partner; limited ones keep a minimum.
module atahp_port
	import atahp_pkg::*;
#(
	parameter int WAIT_LIMIT = IORDY_MAX_LOW_CYC - 1,
	parameter int MLI_LIMIT  = HOST_MLI_CYC
) (
	input  wire logic            core_clk,
	input  wire logic            resetn,
	input  wire logic [2:0]      pio_mode,
	input  wire atahp_host_in_t  host,
	output atahp_dev_out_t       dev,
	output atahp_usr_req_t       usr_req,
	input  wire logic            usr_ready,
	input  wire logic [15:0]     usr_rdata,
	input  wire logic            usr_dma_req,
	input  wire logic [15:0]     usr_dma_rdata,
	output logic                 dma_take,
	output logic                 dma_wr,
	output logic [15:0]          dma_wdata
);
	typedef struct packed {
		atahp_state_t   st;
		logic           rd_q;
		logic           wr_q;
		logic           dmack_q;
		logic           is_rd;
		logic           w16;
		logic [15:0]    wcap;
		atahp_dev_out_t dev;
		atahp_usr_req_t req;
		logic           dma_take;
		logic           dma_wr;
		logic [15:0]    dma_wdata;
	} atahp_core_t;

	atahp_core_t s;
	atahp_core_t next_s;
	logic        wait_done;
	logic        mli_done;
	logic        rd_fall;
	logic        wr_fall;
	logic        wr_up;
	logic        stb_up;
	logic        cs_sel;
	logic        sel16;
	logic        slow;
	logic        dmack_rise;
	logic        wait_start;

	// Strobe edges come from the pin against its value one cycle earlier.
	assign rd_fall    = s.rd_q && !host.rd_n;
	assign wr_fall    = s.wr_q && !host.wr_n;
	assign wr_up      = !s.wr_q && host.wr_n;
	assign stb_up     = (!s.rd_q && host.rd_n) || wr_up;
	assign dmack_rise = !s.dmack_q && host.dmack_n;
	assign cs_sel     = !host.cs0_n || !host.cs1_n;
	assign sel16      = !host.cs0_n && (host.addr == DATA_REG_ADDR);
	assign slow       = atahp_has_iordy(pio_mode);
	assign wait_start = (next_s.st == ST_WAIT) && (s.st != ST_WAIT);

	// Bounds the wait so IORDY cannot stay low past its limit.
	atahp_tmr #(
		.LIMIT (WAIT_LIMIT)
	) u_wait_tmr (
		.core_clk (core_clk),
		.resetn   (resetn),
		.start    (wait_start),
		.done     (wait_done)
	);

	// Keeps DMARQ down for the least interlock time after the host lets go.
	atahp_tmr #(
		.LIMIT (MLI_LIMIT)
	) u_mli_tmr (
		.core_clk (core_clk),
		.resetn   (resetn),
		.start    (dmack_rise),
		.done     (mli_done)
	);

	// Next-state logic for the whole port.
	always_comb begin
		next_s          = s;
		next_s.rd_q     = host.rd_n;
		next_s.wr_q     = host.wr_n;
		next_s.dmack_q  = host.dmack_n;
		next_s.req.valid = 1'b0;
		next_s.dma_take = 1'b0;
		next_s.dma_wr   = 1'b0;
		// The indication follows the address level, only in PIO modes 0 to 2.
		next_s.dev.iocs16_n = !(sel16 && atahp_has_iocs16(pio_mode));
		// In fast modes IORDY is released to the host's pull-up.
		next_s.dev.iordy_oe_n = !slow;
		if (!slow) begin
			next_s.dev.iordy = 1'b1;
		end
		// Write data is taken from the last cycle the strobe was low.
		if (!host.wr_n) begin
			next_s.wcap = host.wdata;
		end
		// Data bus is let go the cycle after the read strobe is seen high.
		if (host.rd_n) begin
			next_s.dev.data_oe_n = 1'b1;
		end
		case (s.st)
			ST_IDLE: begin
				if ((rd_fall || wr_fall) && !host.dmack_n) begin
					if (rd_fall) begin
						next_s.dev.rdata     = usr_dma_rdata;
						next_s.dev.data_oe_n = 1'b0;
						next_s.dma_take      = 1'b1;
					end
					next_s.st = ST_DMA;
				end else if ((rd_fall || wr_fall) && cs_sel) begin
					next_s.is_rd       = rd_fall;
					next_s.w16         = sel16;
					next_s.req.valid   = rd_fall;
					next_s.req.write   = wr_fall;
					next_s.req.width16 = sel16;
					next_s.req.cs1     = !host.cs1_n;
					next_s.req.addr    = host.addr;
					next_s.dev.data_oe_n = !rd_fall;
					// Pull IORDY low at once; a fast answer lifts it
					// before the host samples, so no wait results.
					if (slow) begin
						next_s.dev.iordy = 1'b0;
					end
					next_s.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (stb_up) begin
					// Host ended the cycle on its own timing.
					next_s.dev.iordy = 1'b1;
					next_s.req.valid = !s.is_rd;
					next_s.req.wdata = next_s.wcap;
					next_s.st        = ST_IDLE;
				end else if ((usr_ready && !s.req.valid) || wait_done) begin
					// Data and IORDY rise on the same edge.
					if (s.is_rd) begin
						next_s.dev.rdata = s.w16 ? usr_rdata :
							{8'h00, usr_rdata[7:0]};
					end
					next_s.dev.iordy = 1'b1;
					next_s.st        = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (stb_up) begin
					next_s.req.valid = !s.is_rd;
					next_s.req.wdata = next_s.wcap;
					next_s.st        = ST_IDLE;
				end
			end
			ST_DMA: begin
				if (rd_fall) begin
					next_s.dev.rdata     = usr_dma_rdata;
					next_s.dev.data_oe_n = 1'b0;
					next_s.dma_take      = 1'b1;
				end
				if (wr_up) begin
					next_s.dma_wr    = 1'b1;
					next_s.dma_wdata = s.wcap;
				end
				if (host.dmack_n && host.rd_n && host.wr_n) begin
					next_s.st = ST_IDLE;
				end
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase
		// Request follows the back end; the interlock holds it down.
		next_s.dev.dmarq = usr_dma_req && mli_done
			&& !dmack_rise;
	end

	// Registers the port state held in s, outputs included; the two timers and low_cnt keep their own registers.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '{st: ST_IDLE, rd_q: 1'b1, wr_q: 1'b1, dmack_q: 1'b1,
				is_rd: 1'b0, w16: 1'b0, wcap: RDATA_RESET,
				dev: '{rdata: RDATA_RESET, data_oe_n: 1'b1, iordy: 1'b1,
					iordy_oe_n: 1'b1, iocs16_n: 1'b1, dmarq: 1'b0},
				req: '0, dma_take: 1'b0, dma_wr: 1'b0,
				dma_wdata: RDATA_RESET};
		end else begin
			s <= next_s;
		end
	end

	assign dev       = s.dev;
	assign usr_req   = s.req;
	assign dma_take  = s.dma_take;
	assign dma_wr    = s.dma_wr;
	assign dma_wdata = s.dma_wdata;

	// Helper: run length of IORDY held low.
	logic [7:0] low_cnt;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			low_cnt <= 8'h00;
		end else begin
			low_cnt <= s.dev.iordy ? 8'h00 : low_cnt + 8'h01;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence read_strobe_taken;
		rd_fall && host.dmack_n && cs_sel && slow && s.st == ST_IDLE;
	endsequence
	sequence iordy_pulled_low;
		!dev.iordy && !dev.data_oe_n;
	endsequence

	chk_iocs16_fast_mode: assert property (
		!atahp_has_iocs16(pio_mode) |=> dev.iocs16_n)
		else $error("16-bit indication driven in a fast PIO mode");
	chk_no_wait_fast: assert property (
		!slow && $stable(pio_mode) |=> dev.iordy && dev.iordy_oe_n)
		else $error("IORDY driven low in a mode without waits");
	chk_wait_bounded: assert property (
		low_cnt <= 8'(IORDY_MAX_LOW_CYC))
		else $error("IORDY held low beyond its longest time");
	chk_data_release: assert property (
		host.rd_n |=> dev.data_oe_n)
		else $error("Data bus still driven after read strobe ended");
	chk_read_data_valid: assert property (
		s.st == ST_WAIT && s.is_rd && $rose(next_s.dev.iordy) && !stb_up
		&& !wait_done |=> dev.iordy && dev.rdata[7:0] == $past(usr_rdata[7:0]))
		else $error("IORDY rose without the read data");
	chk_wait_cause: assert property (
		$fell(dev.iordy) |-> $past(rd_fall || wr_fall))
		else $error("IORDY fell without a strobe");
	chk_wait_steps: assert property (
		read_strobe_taken |=> iordy_pulled_low)
		else $error("Slow-mode read did not open a wait");
	chk_byte_width: assert property (
		!dev.data_oe_n && s.st != ST_DMA && !s.w16 && s.st == ST_HOLD
		|-> dev.rdata[15:8] == 8'h00)
		else $error("Upper byte driven on an 8-bit access");
	chk_dmarq_pause: assert property (
		!usr_dma_req |=> !dev.dmarq)
		else $error("DMARQ not dropped after the back end paused");
	chk_mli_gap: assert property (
		$rose(host.dmack_n) |=> !dev.dmarq [*2])
		else $error("DMARQ reasserted inside the interlock time");

endmodule

// [test/atahp_host_model.sv]
// Behavioural host bus controller for the device end of the disk port.
// Assumes it is called from the testbench; it drives pins just after edges.
`timescale 1ns/1ps
module atahp_host_model
	import atahp_pkg::*;
(
	input  wire logic           core_clk,
	input  wire atahp_dev_out_t dev,
	output atahp_host_in_t      host
);
	// Active and recovery spans cover the slowest mode and 8-bit strobes.
	localparam int ACT = 30;
	localparam int REC = 31;
	logic iordy_w;

	// The pull-up gives IORDY a high level whenever the device lets go.
	assign iordy_w = dev.iordy_oe_n ? 1'b1 : dev.iordy;

	// All strobes idle high and the select is parked on no register.
	initial host = {2'b11, 3'h7, 3'b111, 16'h5a5a};

	// One PIO cycle; a low IORDY past the setup point stretches the strobe.
	task automatic pio(input logic rd, input logic cs1, input logic [2:0] a,
		input logic [15:0] wd, output logic [15:0] rdat, output int lowc,
		output logic oe);
		int n;
		@(posedge core_clk);
		#1;
		host.cs0_n = cs1;
		host.cs1_n = !cs1;
		host.addr = a;
		host.wdata = wd;
		repeat (8) @(posedge core_clk);
		#1;
		host.rd_n = !rd;
		host.wr_n = rd;
		lowc = 0;
		n = 0;
		while ((n < ACT || !iordy_w) && n < 400) begin
			@(posedge core_clk);
			#1;
			n++;
			if (!iordy_w)
				lowc++;
		end
		rdat = dev.rdata;
		host.rd_n = 1'b1;
		host.wr_n = 1'b1;
		// One edge after the strobe rises the bus must already be free.
		@(posedge core_clk);
		#1;
		oe = dev.data_oe_n;
		host.wdata = ~wd;
		repeat (REC) @(posedge core_clk);
		#1;
	endtask

	// A multiword DMA burst of whole 16-bit words under the acknowledge.
	task automatic dma(input logic rd, input int words, input logic [15:0] wd,
		output logic [15:0] rdat);
		@(posedge core_clk);
		#1;
		host.dmack_n = 1'b0;
		host.wdata = wd;
		for (int i = 0; i < words; i++) begin
			repeat (2) @(posedge core_clk);
			#1;
			host.rd_n = !rd;
			host.wr_n = rd;
			repeat (22) @(posedge core_clk);
			#1;
			rdat = dev.rdata;
			host.rd_n = 1'b1;
			host.wr_n = 1'b1;
			repeat (26) @(posedge core_clk);
		end
		#1;
		host.dmack_n = 1'b1;
		host.wdata = ~wd;
	endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the device end of the disk port.
// Assumes the host model above and a back end held by this module.
`timescale 1ns/1ps
module testbench;
	import atahp_pkg::*;
	localparam int WL = 4;
	logic           core_clk;
	logic           resetn;
	logic [2:0]     pio_mode;
	logic           usr_ready;
	logic [15:0]    usr_rdata;
	logic           usr_dma_req;
	logic [15:0]    usr_dma_rdata;
	logic           dma_take;
	logic           dma_wr;
	logic [15:0]    dma_wdata;
	atahp_host_in_t host;
	atahp_dev_out_t dev;
	atahp_usr_req_t usr_req;
	atahp_usr_req_t last_req;
	int             fail_count;
	int             checks_done;
	int             takes;
	int             wrs;
	int             lowc;
	logic [15:0]    rd_seen;
	logic           oe_late;

	atahp_port #(.WAIT_LIMIT(WL)) DUT (.core_clk(core_clk), .resetn(resetn),
		.pio_mode(pio_mode), .host(host), .dev(dev), .usr_req(usr_req),
		.usr_ready(usr_ready), .usr_rdata(usr_rdata),
		.usr_dma_req(usr_dma_req), .usr_dma_rdata(usr_dma_rdata),
		.dma_take(dma_take), .dma_wr(dma_wr), .dma_wdata(dma_wdata));
	atahp_host_model HOST (.core_clk(core_clk), .dev(dev), .host(host));

	// The clock toggles every half period.
	always #5 core_clk = ~core_clk;

	// Records back-end requests and DMA word events.
	always @(posedge core_clk) begin
		if (usr_req.valid === 1'b1)
			last_req <= usr_req;
		if (dma_take === 1'b1)
			takes <= takes + 1;
		if (dma_wr === 1'b1)
			wrs <= wrs + 1;
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic t_read();
		pio_mode = 3'h0;
		usr_rdata = 16'hbe71;
		HOST.pio(1'b1, 1'b0, 3'h0, 16'h0, rd_seen, lowc, oe_late);
		check("read16", rd_seen, 16'hbe71);
		check("req width16", 16'(last_req.width16), 16'h1);
		check("req write", 16'(last_req.write), 16'h0);
		check("iocs16", 16'(dev.iocs16_n), 16'h0);
		check("release", 16'(oe_late), 16'h1);
		pio_mode = 3'h2;
		HOST.pio(1'b1, 1'b1, 3'h6, 16'h0, rd_seen, lowc, oe_late);
		check("read8", rd_seen, 16'h0071);
		check("req cs1", 16'(last_req.cs1), 16'h1);
		check("req addr", 16'(last_req.addr), 16'h6);
		check("iocs16 reg", 16'(dev.iocs16_n), 16'h1);
	endtask

	// Modes 3 and 4 still wait but no longer give the 16-bit indication.
	task automatic t_timeout();
		usr_ready = 1'b0;
		for (int m = 3; m < 5; m++) begin
			pio_mode = m[2:0];
			HOST.pio(1'b1, 1'b0, 3'h0, 16'h0, rd_seen, lowc, oe_late);
			check("waited", 16'(lowc > 0), 16'h1);
			check("wait bound", 16'(lowc <= WL + 1), 16'h1);
			check("iocs16 m34", 16'(dev.iocs16_n), 16'h1);
			check("iordy oe", 16'(dev.iordy_oe_n), 16'h0);
		end
		usr_ready = 1'b1;
	endtask

	task automatic t_fast();
		usr_rdata = 16'h2d4b;
		for (int m = 5; m < 7; m++) begin
			pio_mode = m[2:0];
			HOST.pio(1'b1, 1'b0, 3'h0, 16'h0, rd_seen, lowc, oe_late);
			check("no wait", 16'(lowc), 16'h0);
			check("iordy off", 16'(dev.iordy_oe_n), 16'h1);
			check("fast data", rd_seen, 16'h2d4b);
			check("fast release", 16'(oe_late), 16'h1);
		end
	endtask

	task automatic t_write();
		pio_mode = 3'h1;
		HOST.pio(1'b0, 1'b0, 3'h0, 16'ha5c3, rd_seen, lowc, oe_late);
		check("wr data", last_req.wdata, 16'ha5c3);
		check("wr flag", 16'(last_req.write), 16'h1);
		HOST.pio(1'b0, 1'b1, 3'h5, 16'h7e19, rd_seen, lowc, oe_late);
		check("wr8 data", {8'h00, last_req.wdata[7:0]}, 16'h0019);
		check("wr8 width", 16'(last_req.width16), 16'h0);
	endtask

	// Polls the request just after each edge, where it has settled.
	task automatic wait_rq();
		for (int n = 0; n < 50 && dev.dmarq !== 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		check("dmarq up", 16'(dev.dmarq), 16'h1);
	endtask

	task automatic t_dma();
		pio_mode = 3'h0;
		usr_dma_rdata = 16'h3c96;
		usr_dma_req = 1'b1;
		wait_rq();
		usr_dma_req = 1'b0;
		repeat (3) @(posedge core_clk);
		#1;
		check("dmarq pause", 16'(dev.dmarq), 16'h0);
		usr_dma_req = 1'b1;
		wait_rq();
		HOST.dma(1'b1, 2, 16'h0, rd_seen);
		check("dma rdata", rd_seen, 16'h3c96);
		check("dma takes", 16'(takes), 16'h2);
		repeat (2) @(posedge core_clk);
		#1;
		check("interlock", 16'(dev.dmarq), 16'h0);
		wait_rq();
		HOST.dma(1'b0, 1, 16'hc05e, rd_seen);
		check("dma writes", 16'(wrs), 16'h1);
		check("dma wdata", dma_wdata, 16'hc05e);
		usr_dma_req = 1'b0;
	endtask

	// Main sequence: reset, then every scenario in turn.
	initial begin
		core_clk = 1'b0;
		resetn = 1'b0;
		pio_mode = 3'h0;
		usr_ready = 1'b1;
		usr_rdata = 16'h0;
		usr_dma_req = 1'b0;
		usr_dma_rdata = 16'h0;
		fail_count = 0;
		checks_done = 0;
		takes = 0;
		wrs = 0;
		last_req = '0;
		repeat (16) @(posedge core_clk);
		#1;
		resetn = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		t_read();
		t_timeout();
		t_fast();
		t_write();
		t_dma();
		test_done();
	end

	// Watchdog cuts a hang short well beyond the expected run length.
	initial begin
		#100000;
		fail_count++;
		test_done();
	end
endmodule
